/* verilog/nsta_pkg.sv */
// package of constants and the four-phase instruction cycle divider
package nsta_pkg;
   typedef enum logic [1:0] {
      NSTA_OP_SWAP = 2'h0,
      NSTA_OP_TRD = 2'h1,
      NSTA_OP_TWR = 2'h2,
      NSTA_OP_NONE = 2'h3
   } nsta_op_t;
   typedef enum logic [2:0] {
      NSTA_S_IDLE = 3'h0,
      NSTA_S_C1 = 3'h1,
      NSTA_S_C2 = 3'h2,
      NSTA_S_C3 = 3'h3,
      NSTA_S_PGM = 3'h4
   } nsta_state_t;
   localparam logic [1:0] NSTA_Q_DECODE = 2'h0;
   localparam logic [1:0] NSTA_Q_READ = 2'h1;
   localparam logic [1:0] NSTA_Q_PROC = 2'h2;
   localparam logic [1:0] NSTA_Q_WRITE = 2'h3;
   localparam logic [7:0] NSTA_PCL_ADDR = 8'h02;
   localparam int NSTA_CLK_MHZ = 100;
   localparam int NSTA_PGM_TIME_US = 100;
   localparam int NSTA_PGM_CYCLES = NSTA_PGM_TIME_US * NSTA_CLK_MHZ;
   localparam logic [15:0] NSTA_PTR_RST = 16'h0000;
   localparam logic [15:0] NSTA_LAT_RST = 16'h0000;
endpackage : nsta_pkg

// q phase counter: one count per clock, wraps every instruction cycle
module nsta_qphase (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // phase
   output logic [1:0] q_out
);
   import nsta_pkg::*;
   logic [1:0] q_nxt;
   always_comb begin
      q_nxt = q_out + 2'h1;
   end
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         q_out <= NSTA_Q_DECODE;
      end else begin
         q_out <= q_nxt;
      end
   end
endmodule : nsta_qphase

/* verilog/nsta_core.sv */
// nibble swap and table read/write execution unit
module nsta_core #(
   parameter int PGM_CYCLES = nsta_pkg::NSTA_PGM_CYCLES
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_b_in,
   // instruction issue
   input wire logic op_valid_in,
   input wire nsta_pkg::nsta_op_t op_in,
   input wire logic t_bit_in,
   input wire logic i_bit_in,
   input wire logic d_bit_in,
   input wire logic [7:0] file_addr_in,
   input wire logic [7:0] file_data_in,
   input wire logic target_ext_in,
   input wire logic irq_in,
   // file register side
   output logic file_we_out,
   output logic [7:0] file_waddr_out,
   output logic [7:0] file_wdata_out,
   output logic working_register_we_out,
   output logic [7:0] working_register_data_out,
   output logic status_we_out,
   output logic busy_out,
   output logic done_out,
   output logic [1:0] q_phase_out,
   // program memory side
   input wire logic [15:0] prog_rdata_in,
   output logic [15:0] prog_addr_out,
   output logic [15:0] prog_wdata_out,
   output logic prog_oe_b_out,
   output logic prog_we_b_out,
   output logic eprom_pgm_out,
   output logic eprom_abort_out,
   output logic [15:0] table_pointer_out,
   output logic [15:0] table_latch_out
);
   import nsta_pkg::*;
   logic [1:0] q;
   logic [15:0] rd_meta_r, rd_sync_r;
   nsta_state_t state_r, state_nxt;
   nsta_op_t op_r, op_nxt;
   logic t_r, t_nxt, i_r, i_nxt, d_r, d_nxt, ext_r, ext_nxt;
   logic [7:0] fa_r, fa_nxt, fd_r, fd_nxt;
   logic [15:0] ptr_r, ptr_nxt, lat_r, lat_nxt, paddr_r, paddr_nxt, pwd_r, pwd_nxt;
   logic fwe_r, fwe_nxt, wwe_r, wwe_nxt, busy_r, busy_nxt, done_r, done_nxt;
   logic [7:0] fwa_r, fwa_nxt, fwd_r, fwd_nxt, wd_r, wd_nxt;
   logic oe_b_r, oe_b_nxt, we_b_r, we_b_nxt, pgm_r, pgm_nxt, abort_r, abort_nxt;
   logic [31:0] cnt_r, cnt_nxt;
   logic [15:0] ptr_inc;

   nsta_qphase u_qphase (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .q_out(q)
   );

   // program data arrives from pins: two flops before use
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_meta_r <= 16'h0000;
         rd_sync_r <= 16'h0000;
      end else begin
         rd_meta_r <= prog_rdata_in;
         rd_sync_r <= rd_meta_r;
      end
   end

   always_comb begin
      ptr_inc = i_r ? ptr_r + 16'h0001 : ptr_r;
      state_nxt = state_r;
      op_nxt = op_r;
      t_nxt = t_r;
      i_nxt = i_r;
      d_nxt = d_r;
      ext_nxt = ext_r;
      fa_nxt = fa_r;
      fd_nxt = fd_r;
      ptr_nxt = ptr_r;
      lat_nxt = lat_r;
      paddr_nxt = paddr_r;
      pwd_nxt = lat_r;
      fwe_nxt = 1'b0;
      fwa_nxt = fwa_r;
      fwd_nxt = fwd_r;
      wwe_nxt = 1'b0;
      wd_nxt = wd_r;
      busy_nxt = busy_r;
      done_nxt = 1'b0;
      oe_b_nxt = 1'b1;
      we_b_nxt = 1'b1;
      pgm_nxt = 1'b0;
      abort_nxt = 1'b0;
      cnt_nxt = cnt_r;
      case (state_r)
         NSTA_S_IDLE: begin
            if (op_valid_in && op_in != NSTA_OP_NONE && q == NSTA_Q_DECODE) begin
               op_nxt = op_in;
               t_nxt = t_bit_in;
               i_nxt = i_bit_in;
               d_nxt = d_bit_in;
               ext_nxt = target_ext_in;
               fa_nxt = file_addr_in;
               fd_nxt = file_data_in;
               busy_nxt = 1'b1;
               state_nxt = NSTA_S_C1;
            end
         end
         NSTA_S_C1: begin
            if (q == NSTA_Q_WRITE) begin
               paddr_nxt = ptr_r;
               state_nxt = NSTA_S_C2;
               case (op_r)
                  NSTA_OP_SWAP: begin
                     fwd_nxt = {fd_r[3:0], fd_r[7:4]};
                     wd_nxt = {fd_r[3:0], fd_r[7:4]};
                     fwa_nxt = fa_r;
                     fwe_nxt = d_r;
                     wwe_nxt = !d_r;
                     done_nxt = 1'b1;
                     busy_nxt = 1'b0;
                     state_nxt = NSTA_S_IDLE;
                  end
                  NSTA_OP_TRD: begin
                     fwd_nxt = t_r ? lat_r[15:8] : lat_r[7:0];
                     fwa_nxt = fa_r;
                     fwe_nxt = 1'b1;
                     oe_b_nxt = 1'b0;
                  end
                  NSTA_OP_TWR: begin
                     if (t_r) begin
                        lat_nxt[15:8] = fd_r;
                     end else begin
                        lat_nxt[7:0] = fd_r;
                     end
                  end
                  default: begin
                     busy_nxt = 1'b0;
                     state_nxt = NSTA_S_IDLE;
                  end
               endcase
            end
         end
         NSTA_S_C2: begin
            if (op_r == NSTA_OP_TRD) begin
               oe_b_nxt = (q == NSTA_Q_WRITE);
               if (q == NSTA_Q_WRITE) begin
                  lat_nxt = rd_sync_r;
                  ptr_nxt = ptr_inc;
                  if (fa_r == NSTA_PCL_ADDR) begin
                     state_nxt = NSTA_S_C3;
                  end else begin
                     done_nxt = 1'b1;
                     busy_nxt = 1'b0;
                     state_nxt = NSTA_S_IDLE;
                  end
               end
            end else if (ext_r) begin
               we_b_nxt = !(q == NSTA_Q_PROC);
               if (q == NSTA_Q_WRITE) begin
                  ptr_nxt = ptr_inc;
                  done_nxt = 1'b1;
                  busy_nxt = 1'b0;
                  state_nxt = NSTA_S_IDLE;
               end
            end else if (q == NSTA_Q_WRITE) begin
               pgm_nxt = 1'b1;
               cnt_nxt = 32'h0;
               state_nxt = NSTA_S_PGM;
            end
         end
         NSTA_S_C3: begin
            if (q == NSTA_Q_WRITE) begin
               done_nxt = 1'b1;
               busy_nxt = 1'b0;
               state_nxt = NSTA_S_IDLE;
            end
         end
         NSTA_S_PGM: begin
            cnt_nxt = cnt_r + 32'h1;
            if (irq_in) begin
               abort_nxt = 1'b1;
               done_nxt = 1'b1;
               busy_nxt = 1'b0;
               state_nxt = NSTA_S_IDLE;
            end else if (cnt_r >= 32'(PGM_CYCLES - 1)) begin
               ptr_nxt = ptr_inc;
               done_nxt = 1'b1;
               busy_nxt = 1'b0;
               state_nxt = NSTA_S_IDLE;
            end else begin
               pgm_nxt = 1'b1;
            end
         end
         default: begin
            busy_nxt = 1'b0;
            state_nxt = NSTA_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_r <= NSTA_S_IDLE;
         op_r <= NSTA_OP_NONE;
         t_r <= 1'b0;
         i_r <= 1'b0;
         d_r <= 1'b0;
         ext_r <= 1'b0;
         fa_r <= 8'h00;
         fd_r <= 8'h00;
         ptr_r <= NSTA_PTR_RST;
         lat_r <= NSTA_LAT_RST;
         paddr_r <= 16'h0000;
         pwd_r <= 16'h0000;
         fwe_r <= 1'b0;
         fwa_r <= 8'h00;
         fwd_r <= 8'h00;
         wwe_r <= 1'b0;
         wd_r <= 8'h00;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         oe_b_r <= 1'b1;
         we_b_r <= 1'b1;
         pgm_r <= 1'b0;
         abort_r <= 1'b0;
         cnt_r <= 32'h0;
      end else begin
         state_r <= state_nxt;
         op_r <= op_nxt;
         t_r <= t_nxt;
         i_r <= i_nxt;
         d_r <= d_nxt;
         ext_r <= ext_nxt;
         fa_r <= fa_nxt;
         fd_r <= fd_nxt;
         ptr_r <= ptr_nxt;
         lat_r <= lat_nxt;
         paddr_r <= paddr_nxt;
         pwd_r <= pwd_nxt;
         fwe_r <= fwe_nxt;
         fwa_r <= fwa_nxt;
         fwd_r <= fwd_nxt;
         wwe_r <= wwe_nxt;
         wd_r <= wd_nxt;
         busy_r <= busy_nxt;
         done_r <= done_nxt;
         oe_b_r <= oe_b_nxt;
         we_b_r <= we_b_nxt;
         pgm_r <= pgm_nxt;
         abort_r <= abort_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign file_we_out = fwe_r;
   assign file_waddr_out = fwa_r;
   assign file_wdata_out = fwd_r;
   assign working_register_we_out = wwe_r;
   assign working_register_data_out = wd_r;
   assign status_we_out = 1'b0;
   assign busy_out = busy_r;
   assign done_out = done_r;
   assign q_phase_out = q;
   assign prog_addr_out = paddr_r;
   assign prog_wdata_out = pwd_r;
   assign prog_oe_b_out = oe_b_r;
   assign prog_we_b_out = we_b_r;
   assign eprom_pgm_out = pgm_r;
   assign eprom_abort_out = abort_r;
   assign table_pointer_out = ptr_r;
   assign table_latch_out = lat_r;

   sequence trd_c1_s;
      state_r == NSTA_S_C1 && op_r == NSTA_OP_TRD && q == NSTA_Q_WRITE;
   endsequence
   sequence trd_end_s;
      state_r == NSTA_S_C2 && op_r == NSTA_OP_TRD && q == NSTA_Q_WRITE;
   endsequence

   swap_result_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state_r == NSTA_S_C1 && op_r == NSTA_OP_SWAP && q == NSTA_Q_WRITE) |=>
      (file_wdata_out == {$past(fd_r[3:0]), $past(fd_r[7:4])})
      && (file_we_out == $past(d_r)) && (working_register_we_out == !$past(d_r)))
      else $error("swap result or destination wrong");
   read_byte_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      trd_c1_s |=> file_we_out
      && file_wdata_out == ($past(t_r) ? $past(lat_r[15:8]) : $past(lat_r[7:0])))
      else $error("table read moved wrong latch byte");
   read_load_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      trd_end_s |=> table_latch_out == $past(rd_sync_r))
      else $error("latch not loaded from program memory");
   ptr_step_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      trd_end_s |=> table_pointer_out == $past(ptr_r) + {15'h0, $past(i_r)})
      else $error("pointer step wrong");
   read_oe_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      trd_c1_s |=> (!prog_oe_b_out && prog_addr_out == table_pointer_out) [*4] ##1 prog_oe_b_out)
      else $error("output enable not low for cycle two");
   pcl_extra_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (trd_end_s and fa_r == NSTA_PCL_ADDR) |=> !done_out [*4] ##1 done_out)
      else $error("pcl read not three cycles");
   write_byte_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state_r == NSTA_S_C1 && op_r == NSTA_OP_TWR && q == NSTA_Q_WRITE && t_r) |=>
      table_latch_out == {$past(fd_r), $past(lat_r[7:0])})
      else $error("latch high byte write wrong");
   ext_strobe_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state_r == NSTA_S_C2 && op_r == NSTA_OP_TWR && ext_r && q == NSTA_Q_PROC) |=>
      !prog_we_b_out && prog_wdata_out == table_latch_out ##1 prog_we_b_out && done_out)
      else $error("external write strobe wrong");
   pgm_abort_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      (state_r == NSTA_S_PGM && irq_in) |=> !eprom_pgm_out && eprom_abort_out
      && table_pointer_out == $past(ptr_r))
      else $error("interrupt did not stop programming");
   no_flags_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
      busy_out |-> !status_we_out)
      else $error("status flags touched");
endmodule : nsta_core

/* dv/nsta_prog_mem.sv */
// program memory model answering the table access unit
module nsta_prog_mem (
   // clock
   input wire logic clk_in,
   // bus from the unit
   input wire logic [15:0] prog_addr_in,
   input wire logic [15:0] prog_wdata_in,
   input wire logic prog_oe_b_in,
   input wire logic prog_we_b_in,
   input wire logic eprom_pgm_in,
   input wire logic eprom_abort_in,
   // read data back to the unit
   output logic [15:0] prog_rdata_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] words [logic [15:0]];
   logic [15:0] last_r = 16'h0000;
   logic [15:0] pa_r = 16'h0000;
   logic [15:0] pd_r = 16'h0000;
   logic pgm_r = 1'h0;
   logic cut_r = 1'h0;
   function automatic logic [15:0] read_word(input logic [15:0] a);
      if (words.exists(a))
         return words[a];
      return a ^ 16'hc3a5;
   endfunction : read_word
   // an idle bus shows the inverse of the last word so stale data never passes
   always @(prog_oe_b_in or prog_addr_in or last_r) begin
      prog_rdata_out = prog_oe_b_in ? ~last_r : read_word(prog_addr_in);
   end
   always @(posedge clk_in) begin
      pgm_r <= eprom_pgm_in;
      if (!prog_oe_b_in)
         last_r <= read_word(prog_addr_in);
      if (!prog_we_b_in)
         words[prog_addr_in] = prog_wdata_in;
      if (eprom_pgm_in && !pgm_r) begin
         pa_r <= prog_addr_in;
         pd_r <= prog_wdata_in;
         cut_r <= 1'h0;
      end
      if (eprom_abort_in)
         cut_r <= 1'h1;
      // a cut programming run leaves the word as it was
      if (pgm_r && !eprom_pgm_in && !cut_r && !eprom_abort_in)
         words[pa_r] = pd_r;
   end
endmodule : nsta_prog_mem

/* dv/nibble_swap_and_table_access_bench.sv */
// self-checking bench of the nibble swap and table access unit
module nibble_swap_and_table_access_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import nsta_pkg::*;
   typedef struct {
      nsta_op_t op;
      logic t, i, d;
      logic [7:0] fa, fd;
      logic ext;
      int chk;
      logic [7:0] eb;
      int cyc;
   } nsta_row_t;
   logic clk_in = 1'h0;
   logic rst_b_in = 1'h0;
   logic op_valid_in = 1'h0;
   nsta_op_t op_in = NSTA_OP_NONE;
   logic t_bit_in = 1'h0, i_bit_in = 1'h0, d_bit_in = 1'h0, target_ext_in = 1'h0, irq_in = 1'h0;
   logic [7:0] file_addr_in = 8'h00, file_data_in = 8'h00, file_waddr_out, file_wdata_out;
   logic [7:0] working_register_data_out, got_a, got_b;
   logic file_we_out, working_register_we_out, status_we_out, busy_out, done_out, prog_oe_b_out;
   logic prog_we_b_out, eprom_pgm_out, eprom_abort_out;
   logic [1:0] q_phase_out;
   logic [15:0] prog_rdata_in, prog_addr_out, prog_wdata_out, table_pointer_out, table_latch_out;
   logic [15:0] e_ptr = 16'h0000, e_lat = 16'h0000;
   logic [15:0] e_mem [logic [15:0]];
   int miscompares = 0, n_tests = 0, n_fw = 0, n_ww = 0, n_we = 0, n_ab = 0;
   nsta_row_t rows [8];
   nsta_core #(.PGM_CYCLES(8)) nsta_core_i (
      .clk_in, .rst_b_in, .op_valid_in, .op_in, .t_bit_in, .i_bit_in, .d_bit_in,
      .file_addr_in, .file_data_in, .target_ext_in, .irq_in, .file_we_out, .file_waddr_out,
      .file_wdata_out, .working_register_we_out, .working_register_data_out, .status_we_out, .busy_out, .done_out,
      .q_phase_out, .prog_rdata_in, .prog_addr_out, .prog_wdata_out, .prog_oe_b_out,
      .prog_we_b_out, .eprom_pgm_out, .eprom_abort_out, .table_pointer_out, .table_latch_out);
   nsta_prog_mem nsta_prog_mem_i (
      .clk_in, .prog_addr_in(prog_addr_out), .prog_wdata_in(prog_wdata_out),
      .prog_oe_b_in(prog_oe_b_out), .prog_we_b_in(prog_we_b_out),
      .eprom_pgm_in(eprom_pgm_out), .eprom_abort_in(eprom_abort_out),
      .prog_rdata_out(prog_rdata_in));
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict
   function automatic logic [15:0] ew(input logic [15:0] a);
      return e_mem.exists(a) ? e_mem[a] : a ^ 16'hc3a5;
   endfunction : ew
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      repeat (2000) @(posedge clk_in);
      miscompares++;
      give_verdict();
   end
   always @(posedge clk_in) begin
      if (file_we_out) begin
         n_fw++;
         got_b = file_wdata_out;
         got_a = file_waddr_out;
      end
      if (working_register_we_out) begin
         n_ww++;
         got_b = working_register_data_out;
      end
      n_we += int'(prog_we_b_out === 1'h0);
      n_ab += int'(eprom_abort_out === 1'h1);
      chk("status_we", 16'h0000, 16'(status_we_out));
   end
   task automatic chk_rst();
      chk("busy", 16'h0000, 16'(busy_out));
      chk("oe_b", 16'h0001, 16'(prog_oe_b_out));
      chk("we_b", 16'h0001, 16'(prog_we_b_out));
      chk("pointer", 16'h0000, table_pointer_out);
      chk("latch", 16'h0000, table_latch_out);
   endtask : chk_rst
   task automatic run(input nsta_row_t r, input logic irq);
      int n;
      logic [15:0] a;
      // the issue edge closes the first clock of the instruction
      n = 1;
      a = e_ptr;
      do begin
         @(posedge clk_in);
         #1;
      end while (q_phase_out !== 2'h0);
      n_fw = 0;
      n_ww = 0;
      n_we = 0;
      n_ab = 0;
      op_in = r.op;
      t_bit_in = r.t;
      i_bit_in = r.i;
      d_bit_in = r.d;
      file_addr_in = r.fa;
      file_data_in = r.fd;
      target_ext_in = r.ext;
      op_valid_in = 1'h1;
      @(posedge clk_in);
      #1 op_valid_in = 1'h0;
      while (done_out !== 1'h1 && n < 60) begin
         irq_in = irq & eprom_pgm_out;
         @(posedge clk_in);
         #1 n++;
      end
      irq_in = 1'h0;
      @(posedge clk_in);
      #1 chk("done", 16'h0000, 16'(done_out));
      if (r.op == NSTA_OP_TRD) begin
         e_lat = ew(a);
         e_ptr = a + 16'(r.i);
      end
      if (r.op == NSTA_OP_TWR) begin
         if (r.t)
            e_lat[15:8] = r.fd;
         else
            e_lat[7:0] = r.fd;
         if (!irq) begin
            e_mem[a] = e_lat;
            e_ptr = a + 16'(r.i);
         end
         chk("word", ew(a), nsta_prog_mem_i.read_word(a));
         chk("strobes", 16'(r.ext), 16'(n_we));
         chk("aborts", 16'(irq), 16'(n_ab));
      end
      if (r.cyc != 0) chk("cycles", 16'(r.cyc), 16'(n));
      chk("latch", e_lat, table_latch_out);
      chk("pointer", e_ptr, table_pointer_out);
      chk("file writes", 16'(r.chk == 1), 16'(n_fw));
      chk("working_register writes", 16'(r.chk == 2), 16'(n_ww));
      if (r.chk != 0) chk("byte", 16'(r.eb), 16'(got_b));
      if (r.chk == 1) chk("addr", 16'(r.fa), 16'(got_a));
   endtask : run
   initial begin
      rows[0] = '{NSTA_OP_SWAP, 1'h0, 1'h0, 1'h0, 8'h20, 8'h53, 1'h0, 2, 8'h35, 4};
      rows[1] = '{NSTA_OP_SWAP, 1'h0, 1'h0, 1'h1, 8'h21, 8'ha7, 1'h0, 1, 8'h7a, 4};
      rows[2] = '{NSTA_OP_TWR, 1'h1, 1'h1, 1'h0, 8'h22, 8'h53, 1'h1, 0, 8'h00, 8};
      rows[3] = '{NSTA_OP_TWR, 1'h0, 1'h0, 1'h0, 8'h23, 8'h55, 1'h1, 0, 8'h00, 8};
      rows[4] = '{NSTA_OP_TRD, 1'h1, 1'h0, 1'h0, 8'h24, 8'h00, 1'h0, 1, 8'h53, 8};
      rows[5] = '{NSTA_OP_TRD, 1'h0, 1'h1, 1'h0, 8'h25, 8'h00, 1'h0, 1, 8'h55, 8};
      rows[6] = '{NSTA_OP_TRD, 1'h1, 1'h1, 1'h0, 8'h26, 8'h00, 1'h0, 1, 8'h53, 8};
      rows[7] = '{NSTA_OP_TRD, 1'h0, 1'h1, 1'h0, NSTA_PCL_ADDR, 8'h00, 1'h0, 1, 8'ha7, 12};
      repeat (5) @(posedge clk_in);
      chk_rst();
      #1 rst_b_in = 1'h1;
      foreach (rows[k]) run(rows[k], 1'h0);
      // internal programming, then one cut short by an interrupt
      run('{NSTA_OP_TWR, 1'h1, 1'h1, 1'h0, 8'h27, 8'h9e, 1'h0, 0, 8'h00, 16}, 1'h0);
      run('{NSTA_OP_TWR, 1'h0, 1'h1, 1'h0, 8'h28, 8'h11, 1'h0, 0, 8'h00, 0}, 1'h1);
      // reset in the middle of a table read
      op_in = NSTA_OP_TRD;
      op_valid_in = 1'h1;
      repeat (6) @(posedge clk_in);
      #1 op_valid_in = 1'h0;
      chk("oe_b mid read", 16'h0000, 16'(prog_oe_b_out));
      rst_b_in = 1'h0;
      #1 chk_rst();
      repeat (5) @(posedge clk_in);
      #1 rst_b_in = 1'h1;
      e_ptr = 16'h0000;
      e_lat = 16'h0000;
      run(rows[0], 1'h0);
      give_verdict();
   end
endmodule : nibble_swap_and_table_access_bench
